// ### design/irc_consts.svh
// Purpose: offsets, field positions, reset values and opcodes of the remote core
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: opcode layout is the core's own
`ifndef IRC_CONSTS_SVH
`define IRC_CONSTS_SVH
`define IRC_CTRL_OFS 12'h000
`define IRC_LDADDR_OFS 12'h004
`define IRC_LDDATA_OFS 12'h008
`define IRC_STATUS_OFS 12'h00C
`define IRC_CTRL_RUN_BIT 0
`define IRC_ST_PC_LSB 0
`define IRC_ST_ACC_LSB 10
`define IRC_ST_TMP_LSB 14
`define IRC_ST_LP_LSB 18
`define IRC_ST_FP_BIT 22
`define IRC_ST_CY_BIT 23
`define IRC_ST_SF_BIT 24
`define IRC_ST_STOP_BIT 25
`define IRC_ST_ZSEL_LSB 26
`define IRC_PC_RESET 10'h000
`define IRC_ZSEL_RESET 3'h6
`define IRC_ROM_WORDS 1024
`define IRC_RAM_WORDS 32
`define IRC_OP_NOP 8'h00
`define IRC_OP_RET 8'h01
`define IRC_OP_SETCY 8'h02
`define IRC_OP_CLRCY 8'h03
`define IRC_OP_SETH 8'h04
`define IRC_OP_CLRH 8'h05
`define IRC_OP_IFOCY 8'h06
`define IRC_OP_INCL 8'h07
`define IRC_OP_STAP 8'h08
`define IRC_OP_XCHP 8'h09
`define IRC_OP_IFEQM 8'h0A
`define IRC_OP_XAB 8'h0B
`define IRC_OP_LDM 8'h0C
`define IRC_OP_ADDM 8'h0D
`define IRC_OP_HFROMA 8'h0E
`define IRC_OP_AFROMH 8'h0F
`define IRC_OP_OUTC 8'h10
`define IRC_OP_SETF 8'h11
`define IRC_OP_CLRF 8'h12
`define IRC_OP_SETG 8'h13
`define IRC_OP_CLRG 8'h14
`define IRC_OP_SETK 8'h15
`define IRC_OP_CLRK 8'h16
`define IRC_OP_STOP 8'h17
`define IRC_OP_IND 8'h18
`define IRC_OP_INE 8'h19
`define IRC_OP_LDZ 8'h1A
`define IRC_OP_ALFROML 8'h1B
`define IRC_GRP_MBIT 4'h2
`define IRC_GRP_IFEQN 4'h3
`define IRC_GRP_LDA 4'h4
`define IRC_GRP_LDL 4'h5
`define IRC_GRP_ADDN 4'h6
`define IRC_GRP_FAR 4'h7
`define IRC_GRP_JMP 2'b10
`define IRC_GRP_CAL 2'b11
`define IRC_MBIT_IFO 2'b00
`define IRC_MBIT_SET 2'b01
`define IRC_MBIT_CLR 2'b10
`define IRC_FAR_CALL_BIT 6
`endif

// ### design/irc_pkg.sv
// Purpose: types of the remote core
// Assumes: constants live in irc_consts.svh
// Notes: state codes are Gray along idle, execute, operand
package irc_pkg;
  typedef enum logic [1:0] {
    IRC_ST_IDLE = 2'b00,
    IRC_ST_EXEC = 2'b01,
    IRC_ST_OPND = 2'b11
  } irc_state_t;
  typedef logic [9:0] irc_pc_t;
endpackage

// ### design/irc_core.sv
// Purpose: four-bit remote transmitter core with APB program loading
// Assumes: one clock pclk, key inputs synchronous, one instruction per cycle, two cycles for an executed far op
// Notes: ROM loaded over APB while run is low
//
// Decided for this implementation: the register offsets and the APB register port.
`include "irc_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module irc_core (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Key matrix
  input wire logic [3:0] key_sense_d,
  input wire logic [3:0] key_sense_e,
  output logic [7:0] scan_out,
  output logic aux_out_g,
  output logic aux_out_k,
  // Infrared drive, open drain
  output logic ir_drive_pin_o,
  output logic ir_drive_pin_oe_n
);
  import irc_pkg::*;

  function automatic irc_pc_t pc_inc(input irc_pc_t p);
    logic fb;
    // Extra zero term makes all 64 lower states reachable
    fb = p[5] ^ p[4] ^ (p[4:0] == 5'h00);
    return {p[9:6], p[4:0], fb};
  endfunction

  function automatic logic [7:0] car_shape(input logic [2:0] z);
    // Period in upper nibble, high count in lower
    unique case (z)
      3'h0: return 8'hC6;
      3'h1: return 8'hC4;
      3'h2: return 8'hC3;
      3'h3: return 8'h84;
      3'h4: return 8'h82;
      3'h5: return 8'hB4;
      3'h6: return 8'h00;
      3'h7: return 8'h00;
    endcase
  endfunction

  logic [7:0] rom [`IRC_ROM_WORDS];
  logic [3:0] ram [`IRC_RAM_WORDS];

  irc_state_t st_r, st_nxt;
  irc_pc_t pc_r, pc_nxt, stk1_r, stk1_nxt, stk2_r, stk2_nxt;
  logic [3:0] acc_r, acc_nxt, tmp_r, tmp_nxt, lp_r, lp_nxt, far_hi_r, far_hi_nxt;
  logic fp_r, fp_nxt, cy_r, cy_nxt, sf_r, sf_nxt;
  logic [2:0] zsel_r, zsel_nxt, carm_r, carm_nxt;
  logic ch_lda_r, ch_lda_nxt, ch_ldl_r, ch_ldl_nxt, ch_h_r, ch_h_nxt;
  logic stop_r, stop_nxt, g_r, g_nxt, k_r, k_nxt, outd_r, outd_nxt;
  logic [7:0] scan_r, scan_nxt;
  logic ram_we;
  logic [3:0] ram_wd;
  logic [3:0] cnt_r;
  logic run_r;
  logic [9:0] ldaddr_r;

  // APB decode
  wire acc_phase = psel & penable & pready;
  wire wr_en = acc_phase & pwrite;
  wire hit_ctrl = paddr == `IRC_CTRL_OFS;
  wire hit_ldaddr = paddr == `IRC_LDADDR_OFS;
  wire hit_lddata = paddr == `IRC_LDDATA_OFS;
  wire hit_status = paddr == `IRC_STATUS_OFS;
  wire mapped = hit_ctrl | hit_ldaddr | hit_lddata | hit_status;
  wire rom_we = wr_en & hit_lddata;
  wire [31:0] status_w = {3'h0, zsel_r, stop_r, sf_r, cy_r, fp_r, lp_r, tmp_r,
                          acc_r, pc_r};
  wire [31:0] rd_mux = hit_ctrl ? {31'h0, run_r} :
                       hit_ldaddr ? {22'h0, ldaddr_r} :
                       hit_lddata ? {24'h0, rom[ldaddr_r]} :
                       hit_status ? status_w : 32'h0;

  // Instruction decode
  wire [7:0] op = rom[pc_r];
  wire [4:0] ram_a = {fp_r, lp_r};
  wire [3:0] mem = ram[ram_a];
  wire [3:0] lp_inc = lp_r + 4'h1;
  wire [4:0] sum_m = {1'b0, acc_r} + {1'b0, mem};
  wire [4:0] sum_n = {1'b0, acc_r} + {1'b0, op[3:0]};
  wire is_lda = op[7:4] == `IRC_GRP_LDA;
  wire is_ldl = op[7:4] == `IRC_GRP_LDL;
  wire is_hbit = (op == `IRC_OP_SETH) | (op == `IRC_OP_CLRH);
  wire is_far = op[7:4] == `IRC_GRP_FAR;
  wire chain_skip = (is_lda & ch_lda_r) | (is_ldl & ch_ldl_r) | (is_hbit & ch_h_r);
  wire key_wake = (key_sense_d != 4'hF) | (key_sense_e != 4'hF);
  wire [7:0] shape = car_shape(carm_r);
  wire car_none = shape[7:4] == 4'h0;
  wire cnt_wrap = cnt_r == shape[7:4] - 4'h1;
  wire car_hi = car_none | (cnt_r < shape[3:0]);
  irc_pc_t pc_seq;
  assign pc_seq = pc_inc(pc_r);

  always_comb begin
    st_nxt = st_r;
    pc_nxt = pc_r;
    stk1_nxt = stk1_r;
    stk2_nxt = stk2_r;
    acc_nxt = acc_r;
    tmp_nxt = tmp_r;
    lp_nxt = lp_r;
    fp_nxt = fp_r;
    cy_nxt = cy_r;
    sf_nxt = sf_r;
    zsel_nxt = zsel_r;
    carm_nxt = carm_r;
    far_hi_nxt = far_hi_r;
    ch_lda_nxt = ch_lda_r;
    ch_ldl_nxt = ch_ldl_r;
    ch_h_nxt = ch_h_r;
    stop_nxt = stop_r;
    scan_nxt = scan_r;
    g_nxt = g_r;
    k_nxt = k_r;
    outd_nxt = outd_r;
    ram_we = 1'b0;
    ram_wd = acc_r;
    if (!run_r) begin
      st_nxt = IRC_ST_IDLE;
    end else if (stop_r) begin
      // Key press ends stop and restarts from the reset address
      if (key_wake) begin
        stop_nxt = 1'b0;
        pc_nxt = `IRC_PC_RESET;
        st_nxt = IRC_ST_EXEC;
      end
    end else begin
      unique case (st_r)
        IRC_ST_IDLE: begin
          st_nxt = IRC_ST_EXEC;
        end
        IRC_ST_OPND: begin
          pc_nxt = {far_hi_r, op[5:0]};
          if (op[`IRC_FAR_CALL_BIT]) begin
            stk1_nxt = pc_seq;
            stk2_nxt = stk1_r;
          end
          st_nxt = IRC_ST_EXEC;
        end
        IRC_ST_EXEC: begin
          pc_nxt = pc_seq;
          ch_lda_nxt = is_lda;
          ch_ldl_nxt = is_ldl;
          ch_h_nxt = is_hbit;
          if (sf_r) begin
            // Skipped far op also steps over its second byte
            sf_nxt = 1'b0;
            if (is_far) pc_nxt = pc_inc(pc_seq);
          end else if (chain_skip) begin
            pc_nxt = pc_seq;
          end else if (op[7:6] == `IRC_GRP_JMP) begin
            pc_nxt = {pc_r[9:6], op[5:0]};
          end else if (op[7:6] == `IRC_GRP_CAL) begin
            pc_nxt = {pc_r[9:6], op[5:0]};
            stk1_nxt = pc_seq;
            stk2_nxt = stk1_r;
          end else begin
            unique case (op[7:4])
              `IRC_GRP_MBIT: begin
                unique case (op[3:2])
                  `IRC_MBIT_IFO: sf_nxt = ~mem[op[1:0]];
                  `IRC_MBIT_SET: begin
                    ram_we = 1'b1;
                    ram_wd = mem | (4'h1 << op[1:0]);
                  end
                  `IRC_MBIT_CLR: begin
                    ram_we = 1'b1;
                    ram_wd = mem & ~(4'h1 << op[1:0]);
                  end
                  default: ;
                endcase
              end
              `IRC_GRP_IFEQN: sf_nxt = acc_r == op[3:0];
              `IRC_GRP_LDA: acc_nxt = op[3:0];
              `IRC_GRP_LDL: lp_nxt = op[3:0];
              `IRC_GRP_ADDN: begin
                acc_nxt = sum_n[3:0];
                cy_nxt = sum_n[4];
                sf_nxt = sum_n[4];
              end
              `IRC_GRP_FAR: begin
                far_hi_nxt = op[3:0];
                st_nxt = IRC_ST_OPND;
              end
              default: begin
                unique case (op)
                  `IRC_OP_RET: begin
                    pc_nxt = stk1_r;
                    stk1_nxt = stk2_r;
                  end
                  `IRC_OP_SETCY: cy_nxt = 1'b1;
                  `IRC_OP_CLRCY: cy_nxt = 1'b0;
                  `IRC_OP_SETH: fp_nxt = 1'b1;
                  `IRC_OP_CLRH: fp_nxt = 1'b0;
                  `IRC_OP_IFOCY: sf_nxt = ~cy_r;
                  `IRC_OP_INCL: begin
                    lp_nxt = lp_inc;
                    sf_nxt = lp_inc == 4'h0;
                  end
                  `IRC_OP_STAP: begin
                    ram_we = 1'b1;
                    lp_nxt = lp_inc;
                    sf_nxt = lp_inc == 4'h0;
                  end
                  `IRC_OP_XCHP: begin
                    ram_we = 1'b1;
                    acc_nxt = mem;
                    lp_nxt = lp_inc;
                    sf_nxt = lp_inc == 4'h0;
                  end
                  `IRC_OP_IFEQM: sf_nxt = acc_r == mem;
                  `IRC_OP_XAB: begin
                    acc_nxt = tmp_r;
                    tmp_nxt = acc_r;
                  end
                  `IRC_OP_LDM: acc_nxt = mem;
                  `IRC_OP_ADDM: begin
                    acc_nxt = sum_m[3:0];
                    cy_nxt = sum_m[4];
                  end
                  `IRC_OP_HFROMA: fp_nxt = acc_r[0];
                  `IRC_OP_AFROMH: acc_nxt = {3'h0, fp_r};
                  `IRC_OP_OUTC: begin
                    // Carrier shape latched here, so Z must be set first
                    outd_nxt = acc_r[3];
                    carm_nxt = zsel_r;
                  end
                  `IRC_OP_SETF: scan_nxt[lp_r[2:0]] = 1'b1;
                  `IRC_OP_CLRF: scan_nxt[lp_r[2:0]] = 1'b0;
                  `IRC_OP_SETG: g_nxt = 1'b1;
                  `IRC_OP_CLRG: g_nxt = 1'b0;
                  `IRC_OP_SETK: k_nxt = 1'b1;
                  `IRC_OP_CLRK: k_nxt = 1'b0;
                  `IRC_OP_STOP: stop_nxt = 1'b1;
                  `IRC_OP_IND: acc_nxt = key_sense_d;
                  `IRC_OP_INE: acc_nxt = key_sense_e;
                  `IRC_OP_LDZ: zsel_nxt = acc_r[2:0];
                  `IRC_OP_ALFROML: acc_nxt = lp_r;
                  default: ;
                endcase
              end
            endcase
          end
        end
      endcase
    end
  end

  // Core state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= IRC_ST_IDLE;
      pc_r <= `IRC_PC_RESET;
      stk1_r <= `IRC_PC_RESET;
      stk2_r <= `IRC_PC_RESET;
      acc_r <= 4'h0;
      tmp_r <= 4'h0;
      lp_r <= 4'h0;
      fp_r <= 1'b0;
      cy_r <= 1'b0;
      sf_r <= 1'b0;
      zsel_r <= `IRC_ZSEL_RESET;
      carm_r <= `IRC_ZSEL_RESET;
      far_hi_r <= 4'h0;
      ch_lda_r <= 1'b0;
      ch_ldl_r <= 1'b0;
      ch_h_r <= 1'b0;
      stop_r <= 1'b0;
      scan_r <= 8'h00;
      g_r <= 1'b0;
      k_r <= 1'b0;
      outd_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      pc_r <= pc_nxt;
      stk1_r <= stk1_nxt;
      stk2_r <= stk2_nxt;
      acc_r <= acc_nxt;
      tmp_r <= tmp_nxt;
      lp_r <= lp_nxt;
      fp_r <= fp_nxt;
      cy_r <= cy_nxt;
      sf_r <= sf_nxt;
      zsel_r <= zsel_nxt;
      carm_r <= carm_nxt;
      far_hi_r <= far_hi_nxt;
      ch_lda_r <= ch_lda_nxt;
      ch_ldl_r <= ch_ldl_nxt;
      ch_h_r <= ch_h_nxt;
      stop_r <= stop_nxt;
      scan_r <= scan_nxt;
      g_r <= g_nxt;
      k_r <= k_nxt;
      outd_r <= outd_nxt;
    end
  end

  // Memories carry no reset; software loads the ROM before run
  always_ff @(posedge pclk) begin
    if (ram_we) ram[ram_a] <= ram_wd;
    if (rom_we) rom[ldaddr_r] <= pwdata[7:0];
  end

  // Carrier divider restarts when an output write changes the data or carrier shape, for a clean first pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 4'h0;
    end else if (carm_nxt != carm_r || outd_nxt != outd_r || car_none || cnt_wrap) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  // Pins, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir_drive_pin_o <= 1'b0;
      ir_drive_pin_oe_n <= 1'b1;
      scan_out <= 8'h00;
      aux_out_g <= 1'b0;
      aux_out_k <= 1'b0;
    end else begin
      ir_drive_pin_o <= 1'b0;
      // Sinks current while not stopped, data high and carrier phase high
      ir_drive_pin_oe_n <= stop_r | ~(outd_r & car_hi);
      scan_out <= stop_r ? 8'h00 : scan_r;
      aux_out_g <= g_r;
      aux_out_k <= k_r;
    end
  end

  // APB slave: data captured in setup, zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      run_r <= 1'b0;
      ldaddr_r <= 10'h000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel & ~penable) prdata <= pwrite ? 32'h0 : rd_mux;
      if (wr_en & hit_ctrl) run_r <= pwdata[`IRC_CTRL_RUN_BIT];
      if (wr_en & hit_ldaddr) ldaddr_r <= pwdata[9:0];
      if (rom_we) ldaddr_r <= ldaddr_r + 10'h001;
    end
  end
endmodule
`default_nettype wire

// ### test/irc_chk_pkgless.svh
// Purpose: decode of mapped register offsets for the checker
// Assumes: offsets come from irc_consts.svh
// Notes: kept apart so the checker body stays short
`ifndef IRC_CHK_PKGLESS_SVH
`define IRC_CHK_PKGLESS_SVH
`define IRC_CHK_MAPPED(a) ((a) == `IRC_CTRL_OFS || (a) == `IRC_LDADDR_OFS || \
  (a) == `IRC_LDDATA_OFS || (a) == `IRC_STATUS_OFS)
`endif

// ### test/irc_chk.sv
// Purpose: port-level assertions on the remote core
// Assumes: zero-wait APB slave as handed over
// Notes: bound to every irc_core instance
`include "irc_consts.svh"
`include "irc_chk_pkgless.svh"
`timescale 1ns/100ps
`default_nettype none
module irc_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins
  input wire logic [3:0] key_sense_d,
  input wire logic [3:0] key_sense_e,
  input wire logic [7:0] scan_out,
  input wire logic aux_out_g,
  input wire logic aux_out_k,
  input wire logic ir_drive_pin_o,
  input wire logic ir_drive_pin_oe_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic mapped;
  assign mapped = `IRC_CHK_MAPPED(paddr);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_only_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_unmapped: assert property (psel && penable && pready && !mapped |-> pslverr)
    else $error("unmapped access not refused");
  a_err_mapped_only: assert property (pslverr |-> pready && !mapped)
    else $error("pslverr on mapped access");
  a_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_pin_data_low: assert property (ir_drive_pin_o == 1'b0)
    else $error("open drain data not low");
  // Stop clears all lines at once; a wake restoring several lines at once is not exempt here; otherwise one bit per instruction
  a_scan_single_bit: assert property (
    $countones(scan_out ^ $past(scan_out)) > 1 |-> scan_out == 8'h00)
    else $error("several scan bits moved");
endmodule
bind irc_core irc_chk irc_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .key_sense_d(key_sense_d),
  .key_sense_e(key_sense_e), .scan_out(scan_out), .aux_out_g(aux_out_g),
  .aux_out_k(aux_out_k), .ir_drive_pin_o(ir_drive_pin_o),
  .ir_drive_pin_oe_n(ir_drive_pin_oe_n));
`default_nettype wire

// ### test/irc_keys.sv
// Purpose: key matrix and infrared LED beside the core
// Assumes: one key pressed at a time, pull-ups on sense rows
// Notes: a key is sensed only while its scan line sinks
`timescale 1ns/100ps
`default_nettype none
module irc_keys (
  // From core
  input wire logic [7:0] scan_out,
  input wire logic ir_drive_pin_o,
  input wire logic ir_drive_pin_oe_n,
  // From bench
  input wire logic key_dn,
  input wire logic [2:0] key_col,
  input wire logic [2:0] key_row,
  // To core and bench
  output logic [3:0] key_sense_d,
  output logic [3:0] key_sense_e,
  output logic led_on
);
  wire logic hit;
  wire logic [7:0] rows;
  assign hit = key_dn && !scan_out[key_col];
  // Released rows float up, never to the last value
  assign rows = hit ? ~(8'h01 << key_row) : 8'hFF;
  assign key_sense_d = rows[3:0];
  assign key_sense_e = rows[7:4];
  assign led_on = !ir_drive_pin_oe_n && !ir_drive_pin_o;
endmodule
`default_nettype wire

// ### test/testbench.sv
// Purpose: self-checking bench of the remote core
// Assumes: programs are loaded over APB before run is set
// Notes: program bytes follow the polynomial counter order
`include "irc_consts.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin fails++; \
  $display("ERROR %s exp %0h got %0h", nm, ex, got); end end
module testbench;
  import irc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, aux_out_g, aux_out_k, ir_o, ir_oe_n, led_on;
  logic [7:0] scan_out;
  logic [3:0] key_sense_d, key_sense_e;
  logic key_dn = 1'b0;
  logic [2:0] key_col = 3'h3;
  logic [2:0] key_row = 3'h5;
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;
  int lows[9] = '{132, 88, 66, 132, 66, 96, 264, 264, 0};
  irc_core irc_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .key_sense_d(key_sense_d), .key_sense_e(key_sense_e),
    .scan_out(scan_out), .aux_out_g(aux_out_g), .aux_out_k(aux_out_k),
    .ir_drive_pin_o(ir_o), .ir_drive_pin_oe_n(ir_oe_n));
  irc_keys irc_keys_i (.scan_out(scan_out), .ir_drive_pin_o(ir_o),
    .ir_drive_pin_oe_n(ir_oe_n), .key_dn(key_dn), .key_col(key_col), .key_row(key_row),
    .key_sense_d(key_sense_d), .key_sense_e(key_sense_e), .led_on(led_on));
  always #5 pclk = ~pclk;
  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Whole run needs well under this many cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      $display("ERROR timeout exp done got hang");
      summarize();
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [9:0] nxt(input logic [9:0] p);
    return {p[9:6], p[4:0], p[5] ^ p[4] ^ (p[4:0] == 5'h00)};
  endfunction
  task automatic put(input logic [9:0] a, input logic [7:0] d);
    apb(1'b1, `IRC_LDADDR_OFS, {22'h0, a});
    apb(1'b1, `IRC_LDDATA_OFS, {24'h0, d});
  endtask
  task automatic load(input logic [7:0] q[$]);
    logic [9:0] p;
    p = 10'h000;
    foreach (q[i]) begin
      put(p, q[i]);
      p = nxt(p);
    end
  endtask
  task automatic rst_go(input logic go);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    if (go) apb(1'b1, `IRC_CTRL_OFS, 32'h1);
  endtask
  task automatic t_regs;
    rst_go(1'b0);
    apb(1'b0, `IRC_STATUS_OFS, 32'h0);
    `CHK("pc after reset", 10'h000, rd[9:0])
    `CHK("carrier select reset", 3'h6, rd[28:26])
    apb(1'b1, `IRC_STATUS_OFS, 32'hFFFFFFFF);
    apb(1'b0, `IRC_STATUS_OFS, 32'h0);
    `CHK("status after write", 10'h000, rd[9:0])
    apb(1'b1, 12'h010, 32'h1);
    `CHK("unmapped write err", 1'b1, er)
    apb(1'b0, 12'h010, 32'h0);
    `CHK("unmapped read", 33'h100000000, {er, rd})
    put(10'h3FF, 8'hA5);
    apb(1'b1, `IRC_LDADDR_OFS, 32'h3FF);
    apb(1'b0, `IRC_LDDATA_OFS, 32'h0);
    `CHK("last rom byte", 8'hA5, rd[7:0])
  endtask
  task automatic t_flow;
    rst_go(1'b0);
    load('{8'h4F, 8'h41, 8'h61, 8'h45, 8'h0B, 8'hE8, 8'h69, 8'h42, 8'h71, 8'h05});
    put(10'h028, 8'h47);
    put(10'h011, 8'h01);
    put(10'h045, 8'h85);
    apb(1'b1, `IRC_CTRL_OFS, 32'h1);
    repeat (40) @(posedge pclk);
    apb(1'b0, `IRC_STATUS_OFS, 32'h0);
    `CHK("final pc", 10'h045, rd[9:0])
    `CHK("temp after skips", 4'h0, rd[17:14])
    `CHK("acc after add", 4'h0, rd[13:10])
    `CHK("carry, skip", 2'b01, rd[24:23])
  endtask
  task automatic t_carrier;
    int n;
    for (int i = 0; i < 9; i++) begin
      rst_go(1'b0);
      // Carrier select loaded before the output write
      load('{(i < 8) ? (8'h48 | 8'(i)) : 8'h40, 8'h1A, 8'h10, 8'h84});
      apb(1'b1, `IRC_CTRL_OFS, 32'h1);
      repeat (30) @(posedge pclk);
      n = 0;
      repeat (264) begin
        @(posedge pclk);
        if (led_on === 1'b1) n++;
      end
      `CHK("led on cycles", lows[i], n)
    end
  endtask
  task automatic t_scan_stop;
    int n;
    rst_go(1'b0);
    load('{8'h53, 8'h11, 8'h55, 8'h11, 8'h13, 8'h90});
    apb(1'b1, `IRC_CTRL_OFS, 32'h1);
    repeat (20) @(posedge pclk);
    `CHK("scan bits", 10'h0A2, {scan_out, aux_out_g, aux_out_k})
    rst_go(1'b0);
    load('{8'h53, 8'h11, 8'h13, 8'h15, 8'h17});
    apb(1'b1, `IRC_CTRL_OFS, 32'h1);
    repeat (20) @(posedge pclk);
    `CHK("stop pins", 11'h007, {scan_out, aux_out_g, aux_out_k, ir_oe_n})
    apb(1'b0, `IRC_STATUS_OFS, 32'h0);
    `CHK("stop flag", 1'b1, rd[25])
    key_dn <= 1'b1;
    n = 0;
    while (scan_out !== 8'h08 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    `CHK("scan after wake", 8'h08, scan_out)
    key_dn <= 1'b0;
  endtask
  task automatic t_stack;
    rst_go(1'b0);
    // Second file-bit op is chained away, so the pointer stays set
    load('{8'h04, 8'h05, 8'h0F, 8'h84});
    apb(1'b1, `IRC_CTRL_OFS, 32'h1);
    repeat (20) @(posedge pclk);
    apb(1'b0, `IRC_STATUS_OFS, 32'h0);
    `CHK("file pointer, acc", 5'h11, {rd[22], rd[13:10]})
    rst_go(1'b0);
    // Three nested calls, then returns; the oldest address is lost
    put(10'h000, 8'hE8);
    put(10'h028, 8'hC8);
    put(10'h008, 8'hD8);
    put(10'h018, 8'h01);
    put(10'h010, 8'h01);
    put(10'h011, 8'h01);
    apb(1'b1, `IRC_CTRL_OFS, 32'h1);
    repeat (30) @(posedge pclk);
    apb(1'b0, `IRC_STATUS_OFS, 32'h0);
    `CHK("pc after deep returns", 10'h011, rd[9:0])
  endtask
  initial begin
    t_regs();
    t_flow();
    t_stack();
    t_carrier();
    t_scan_stop();
    summarize();
  end
endmodule
`default_nettype wire
